// [shared/mdu_pkg.sv]
// Package: operation codes, operand and result carriers for the multiply/divide unit
package mdu_pkg;
	localparam int unsigned WORD_W      = 32;
	localparam int unsigned REG_IDX_W   = 4;
	localparam int unsigned DIV_STEPS   = 32;
	localparam logic [5:0]  DIV_CNT_RST = 6'h00;

	typedef enum logic [3:0] {
		mul_low_by_low           = 4'h0,
		mul_high_by_low          = 4'h1,
		mul_low_by_high          = 4'h2,
		mul_high_by_high         = 4'h3,
		mul_word_by_low_half     = 4'h4,
		mul_word_by_high_half    = 4'h5,
		unsigned_long_product    = 4'h6,
		unsigned_long_accumulate = 4'h7,
		signed_long_product      = 4'h8,
		signed_long_accumulate   = 4'h9,
		signed_quotient          = 4'ha,
		unsigned_quotient        = 4'hb
	} op_t;

	typedef struct packed {
		op_t                    op;
		logic [WORD_W-1:0]      first_source;
		logic [WORD_W-1:0]      second_source;
		logic [WORD_W-1:0]      acc_low;
		logic [WORD_W-1:0]      acc_high;
		logic [REG_IDX_W-1:0]   dest_low_idx;
		logic [REG_IDX_W-1:0]   dest_high_idx;
		logic [REG_IDX_W-1:0]   first_source_idx;
		logic                   dest_omitted;
	} req_t;

	typedef struct packed {
		logic [WORD_W-1:0]      dest_low_word;
		logic [WORD_W-1:0]      dest_high_word;
		logic [REG_IDX_W-1:0]   dest_low_idx;
		logic [REG_IDX_W-1:0]   dest_high_idx;
		logic                   write_high;
	} rsp_t;
endpackage

// [src/multiply_divide_unit.sv]
// Multiply and divide datapath with valid/ready request and one-cycle done pulse
`timescale 1ns/1ps
module multiply_divide_unit #(
	parameter int unsigned W = mdu_pkg::WORD_W
) (
	input  wire logic           i_sys_clk,
	input  wire logic           i_rst_n,
	input  wire logic           i_clk_en,
	input  wire logic           i_req_valid,
	input  wire mdu_pkg::req_t  i_req,
	output logic                o_req_ready,
	output logic                o_done,
	output mdu_pkg::rsp_t       o_rsp
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_div  = 2'b01,
		st_fix  = 2'b10
	} state_t;

	state_t               state_r;
	state_t               state_nxt;
	logic [5:0]           cnt_r;
	logic [W-1:0]         quo_r;
	logic [W:0]           rem_r;
	logic [W-1:0]         dvs_r;
	logic                 neg_q_r;
	logic                 dz_r;
	logic [mdu_pkg::REG_IDX_W-1:0] qidx_r;
	logic                 done_r;
	mdu_pkg::rsp_t        rsp_r;

	function automatic logic [15:0] pick_half(input logic [31:0] v, input logic top);
		pick_half = top ? v[31:16] : v[15:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Multiply decode

	mdu_pkg::op_t         op;
	logic                 accept;
	logic                 is_div;
	logic                 is_signed_quotient;
	logic [15:0]          half_a;
	logic [15:0]          half_b;
	logic [15:0]          half_w;
	logic signed [31:0]   prod_hh;
	logic signed [47:0]   prod_wh;
	logic [63:0]          prod_u;
	logic signed [63:0]   prod_s;
	logic [63:0]          acc_pair;
	logic [63:0]          long_res;
	logic                 is_long;
	logic [31:0]          mul_word;

	assign op       = i_req.op;
	assign accept   = i_req_valid && o_req_ready && i_clk_en;
	assign is_div   = (op == mdu_pkg::signed_quotient) || (op == mdu_pkg::unsigned_quotient);
	assign is_signed_quotient  = (op == mdu_pkg::signed_quotient);
	assign half_a   = pick_half(i_req.first_source, op[0]);
	assign half_b   = pick_half(i_req.second_source, op[1]);
	assign half_w   = pick_half(i_req.second_source, op[0]);
	assign prod_hh  = $signed(half_a) * $signed(half_b);
	assign prod_wh  = $signed(i_req.first_source) * $signed(half_w);
	assign prod_u   = 64'(i_req.first_source) * 64'(i_req.second_source);
	assign prod_s   = 64'($signed(i_req.first_source)) * 64'($signed(i_req.second_source));
	assign acc_pair = {i_req.acc_high, i_req.acc_low};
	assign is_long  = (op == mdu_pkg::unsigned_long_product) || (op == mdu_pkg::unsigned_long_accumulate)
		|| (op == mdu_pkg::signed_long_product) || (op == mdu_pkg::signed_long_accumulate);
	// No flag outputs exist, so no flags can change
	assign long_res = (op == mdu_pkg::unsigned_long_product)    ? prod_u :
		(op == mdu_pkg::unsigned_long_accumulate) ? (prod_u + acc_pair) :
		(op == mdu_pkg::signed_long_product)      ? prod_s :
		(prod_s + acc_pair);
	assign mul_word = (op == mdu_pkg::mul_word_by_low_half || op == mdu_pkg::mul_word_by_high_half)
		? prod_wh[47:16] : prod_hh;

	////////////////////////////////////////////////////////////////////////////////
	// Divide: restoring, one quotient bit per cycle on magnitudes

	logic [W-1:0]   dvd_mag;
	logic [W-1:0]   dvs_mag;
	logic [W:0]     rem_sh;
	logic [W:0]     rem_try;
	logic           bit_ok;
	logic [W-1:0]   quo_fix;
	logic [mdu_pkg::REG_IDX_W-1:0] qidx_in;

	assign dvd_mag = (is_signed_quotient && i_req.first_source[W-1]) ? W'(-i_req.first_source) : i_req.first_source;
	assign dvs_mag = (is_signed_quotient && i_req.second_source[W-1]) ? W'(-i_req.second_source) : i_req.second_source;
	assign rem_sh  = {rem_r[W-1:0], quo_r[W-1]};
	assign rem_try = rem_sh - {1'b0, dvs_r};
	assign bit_ok  = !rem_try[W];
	// Magnitude division then sign fix truncates toward zero; overflow case wraps to most negative
	assign quo_fix = dz_r ? '0 : (neg_q_r ? W'(-quo_r) : quo_r);
	assign qidx_in = i_req.dest_omitted ? i_req.first_source_idx : i_req.dest_low_idx;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			st_idle: if (accept && is_div) state_nxt = st_div;
			st_div:  if (cnt_r == 6'(mdu_pkg::DIV_STEPS - 1)) state_nxt = st_fix;
			st_fix:  state_nxt = st_idle;
			default: state_nxt = st_idle;
		endcase
	end

	assign o_req_ready = (state_r == st_idle);

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state_r <= st_idle;
			cnt_r   <= mdu_pkg::DIV_CNT_RST;
			quo_r   <= '0;
			rem_r   <= '0;
			dvs_r   <= '0;
			neg_q_r <= 1'b0;
			dz_r    <= 1'b0;
			qidx_r  <= '0;
		end else if (i_clk_en) begin
			state_r <= state_nxt;
			if (accept && is_div) begin
				quo_r   <= dvd_mag;
				rem_r   <= '0;
				dvs_r   <= dvs_mag;
				neg_q_r <= is_signed_quotient && (i_req.first_source[W-1] ^ i_req.second_source[W-1]);
				dz_r    <= (i_req.second_source == '0);
				qidx_r  <= qidx_in;
				cnt_r   <= mdu_pkg::DIV_CNT_RST;
			end else if (state_r == st_div) begin
				quo_r <= {quo_r[W-2:0], bit_ok};
				rem_r <= bit_ok ? rem_try : rem_sh;
				cnt_r <= cnt_r + 6'h01;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			done_r <= 1'b0;
			rsp_r  <= '0;
		end else if (i_clk_en) begin
			done_r <= (accept && !is_div) || (state_r == st_fix);
			if (accept && !is_div) begin
				rsp_r.dest_low_word  <= is_long ? long_res[31:0] : mul_word;
				rsp_r.dest_high_word <= is_long ? long_res[63:32] : 32'h0000_0000;
				rsp_r.dest_low_idx   <= i_req.dest_low_idx;
				rsp_r.dest_high_idx  <= i_req.dest_high_idx;
				rsp_r.write_high     <= is_long;
			end else if (state_r == st_fix) begin
				rsp_r.dest_low_word  <= quo_fix;
				rsp_r.dest_high_word <= 32'h0000_0000;
				rsp_r.dest_low_idx   <= qidx_r;
				rsp_r.dest_high_idx  <= qidx_r;
				rsp_r.write_high     <= 1'b0;
			end
		end
	end

	assign o_done = done_r;
	assign o_rsp  = rsp_r;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	property p_mul_latency;
		@(posedge i_sys_clk) disable iff (!i_rst_n)
		(accept && !is_div) |=> o_done;
	endproperty
	mul_done_a: assert property (p_mul_latency) else $error("multiply did not finish next cycle");

	sequence s_div_start;
		accept && is_div;
	endsequence
	// Helper count of enabled busy cycles; a long repetition would be unrolled by the tools
	logic [5:0]           busy_cnt_r;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			busy_cnt_r <= 6'h00;
		end else if (i_clk_en) begin
			if (accept && is_div) begin
				busy_cnt_r <= 6'h00;
			end else if (state_r != st_idle) begin
				busy_cnt_r <= busy_cnt_r + 6'h01;
			end
		end
	end

	div_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_div_start |=> (state_r == st_div && !o_req_ready)) else $error("divide did not start");

	div_done_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r == st_fix && i_clk_en) |=> o_done) else $error("divide did not finish after fix");

	div_len_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r != st_idle) |-> (busy_cnt_r <= 6'h20)) else $error("divide took too many cycles");

	busy_refuse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r != st_idle) |-> !o_req_ready) else $error("ready while busy");

	hh_prod_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(accept && op == mdu_pkg::mul_high_by_low) |=>
		o_rsp.dest_low_word ==
		32'($signed($past(i_req.first_source[31:16]))) * 32'($signed($past(i_req.second_source[15:0]))))
		else $error("halfword product wrong");

	ulong_hi_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(accept && op == mdu_pkg::unsigned_long_product) |=>
		{o_rsp.dest_high_word, o_rsp.dest_low_word} == 64'($past(i_req.first_source)) * 64'($past(i_req.second_source)))
		else $error("unsigned long product wrong");

	div_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r == st_fix && dz_r && i_clk_en) |=> (o_rsp.dest_low_word == 32'h0000_0000))
		else $error("divide by zero not zero");

	div_dest_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r == st_fix && i_clk_en) |=> (o_rsp.dest_low_idx == $past(qidx_r) && !o_rsp.write_high))
		else $error("quotient register wrong");

	done_pulse_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(o_done && i_clk_en && !accept) |=> !o_done) else $error("done held too long");

	////////////////////////////////////////////////////////////////////////////////
	// Per-operation product checks, widened before multiplying so no product bits are lost

	sequence s_take(mdu_pkg::op_t code);
		accept && (op == code);
	endsequence

	ll_prod_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_take(mdu_pkg::mul_low_by_low) |=> o_rsp.dest_low_word ==
		32'($signed($past(i_req.first_source[15:0]))) * 32'($signed($past(i_req.second_source[15:0]))))
		else $error("low by low product wrong");

	lh_prod_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_take(mdu_pkg::mul_low_by_high) |=> o_rsp.dest_low_word ==
		32'($signed($past(i_req.first_source[15:0]))) * 32'($signed($past(i_req.second_source[31:16]))))
		else $error("low by high product wrong");

	tt_prod_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_take(mdu_pkg::mul_high_by_high) |=> o_rsp.dest_low_word ==
		32'($signed($past(i_req.first_source[31:16]))) * 32'($signed($past(i_req.second_source[31:16]))))
		else $error("high by high product wrong");

	wl_prod_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_take(mdu_pkg::mul_word_by_low_half) |=> o_rsp.dest_low_word ==
		32'((48'($signed($past(i_req.first_source))) * 48'($signed($past(i_req.second_source[15:0])))) >>> 16))
		else $error("word by low half product wrong");

	wh_prod_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_take(mdu_pkg::mul_word_by_high_half) |=> o_rsp.dest_low_word ==
		32'((48'($signed($past(i_req.first_source))) * 48'($signed($past(i_req.second_source[31:16])))) >>> 16))
		else $error("word by high half product wrong");

	ulacc_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_take(mdu_pkg::unsigned_long_accumulate) |=> {o_rsp.dest_high_word, o_rsp.dest_low_word} ==
		64'($past(i_req.first_source)) * 64'($past(i_req.second_source))
		+ {$past(i_req.acc_high), $past(i_req.acc_low)}) else $error("unsigned accumulate wrong");

	slong_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_take(mdu_pkg::signed_long_product) |=> {o_rsp.dest_high_word, o_rsp.dest_low_word} ==
		64'($signed($past(i_req.first_source))) * 64'($signed($past(i_req.second_source))))
		else $error("signed long product wrong");

	slacc_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		s_take(mdu_pkg::signed_long_accumulate) |=> {o_rsp.dest_high_word, o_rsp.dest_low_word} ==
		64'($signed($past(i_req.first_source))) * 64'($signed($past(i_req.second_source)))
		+ {$past(i_req.acc_high), $past(i_req.acc_low)}) else $error("signed accumulate wrong");

	half_high_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(accept && !is_div && !is_long) |=> (o_rsp.dest_high_word == 32'h0000_0000 && !o_rsp.write_high))
		else $error("short product wrote high word");

	long_high_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(accept && is_long) |=> o_rsp.write_high) else $error("long product lost high word");

	mul_idx_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(accept && !is_div) |=> (o_rsp.dest_low_idx == $past(i_req.dest_low_idx)
		&& o_rsp.dest_high_idx == $past(i_req.dest_high_idx))) else $error("product register wrong");

	mul_ready_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(accept && !is_div) |=> o_req_ready) else $error("not ready after multiply");

	////////////////////////////////////////////////////////////////////////////////
	// Divide control and reset checks

	dz_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(accept && is_div && (i_req.second_source == '0)) |=> dz_r) else $error("zero divisor not seen");

	div_fix_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r == st_div && cnt_r == 6'(mdu_pkg::DIV_STEPS - 1) && i_clk_en) |=> (state_r == st_fix))
		else $error("divide did not reach fix step");

	div_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r == st_div && !i_clk_en) |=> ($stable(quo_r) && $stable(cnt_r))) else $error("divide moved while frozen");

	div_idx_hi_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r == st_fix && i_clk_en) |=> (o_rsp.dest_high_idx == $past(qidx_r))) else $error("quotient index wrong");

	ready_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		(state_r == st_idle) |-> o_req_ready) else $error("not ready while idle");

	freeze_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		!i_clk_en |=> ($stable(o_rsp) && $stable(o_done) && $stable(state_r))) else $error("state moved while frozen");

	reset_out_a: assert property (@(posedge i_sys_clk)
		!i_rst_n |=> (!o_done && o_rsp == '0 && o_req_ready)) else $error("outputs not cleared by reset");

endmodule

// [bench/decoder_model.sv]
// Partner model: instruction decoder offering one operation at a time
`timescale 1ns/1ps
module decoder_model (
	input  wire logic     i_sys_clk,
	input  wire logic     i_ready,
	input  wire logic     i_en,
	output logic          o_valid,
	output mdu_pkg::req_t o_req
);
	initial begin
		o_valid = 1'b0;
		o_req = '0;
	end
	////////////////////////////////////////////////////////////////
	// Holds the offer until an enabled edge sees ready, then drops it
	task automatic send(input mdu_pkg::req_t r, output logic taken);
		logic take;
		int k;
		taken = 1'b0;
		@(posedge i_sys_clk);
		o_valid <= 1'b1;
		o_req <= r;
		for (k = 0; k < 200; k++) begin
			@(negedge i_sys_clk);
			take = i_ready & i_en;
			@(posedge i_sys_clk);
			if (take) begin
				taken = 1'b1;
				o_valid <= 1'b0;
				// Released payload goes stale on purpose, so no late sampling passes
				o_req <= ~r;
				break;
			end
		end
	endtask
endmodule

// [bench/tb_top.sv]
// Testbench: random and corner operations against a reference model
`timescale 1ns/1ps
module tb_top;
	logic          i_sys_clk = 1'b0;
	logic          i_rst_n = 1'b0;
	logic          i_clk_en = 1'b1;
	logic          req_valid;
	logic          o_req_ready;
	logic          o_done;
	mdu_pkg::req_t req;
	mdu_pkg::rsp_t o_rsp;
	int            n_mismatch = 0;
	int            compares = 0;

	initial forever #50 i_sys_clk = ~i_sys_clk;

	multiply_divide_unit i_multiply_divide_unit (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
		.i_req_valid(req_valid), .i_req(req), .o_req_ready(o_req_ready), .o_done(o_done), .o_rsp(o_rsp));
	decoder_model i_decoder_model (.i_sys_clk(i_sys_clk), .i_ready(o_req_ready), .i_en(i_clk_en),
		.o_valid(req_valid), .o_req(req));
	////////////////////////////////////////////////////////////////
	function automatic mdu_pkg::rsp_t model(input mdu_pkg::req_t r);
		mdu_pkg::rsp_t      e;
		logic signed [15:0] ha;
		logic signed [15:0] hb;
		logic signed [31:0] sa;
		logic signed [31:0] sb;
		logic signed [47:0] p48;
		logic [63:0]        p;
		e = '0;
		e.dest_low_idx = r.dest_low_idx;
		e.dest_high_idx = r.dest_high_idx;
		ha = r.op[0] ? r.first_source[31:16] : r.first_source[15:0];
		hb = r.op[1] ? r.second_source[31:16] : r.second_source[15:0];
		sa = ha;
		sb = hb;
		case (4'(r.op))
			4'h0, 4'h1, 4'h2, 4'h3: e.dest_low_word = sa * sb;
			4'h4, 4'h5: begin
				hb = r.op[0] ? r.second_source[31:16] : r.second_source[15:0];
				p48 = $signed(r.first_source) * hb;
				e.dest_low_word = p48[47:16];
			end
			4'h6, 4'h7, 4'h8, 4'h9: begin
				if (r.op[3]) p = $signed(r.first_source) * $signed(r.second_source);
				else p = {32'h0, r.first_source} * {32'h0, r.second_source};
				if (r.op[0]) p = p + {r.acc_high, r.acc_low};
				{e.dest_high_word, e.dest_low_word} = p;
				e.write_high = 1'b1;
			end
			default: begin
				e.dest_low_idx = r.dest_omitted ? r.first_source_idx : r.dest_low_idx;
				e.dest_high_idx = e.dest_low_idx;
				if (r.second_source == 32'h0) e.dest_low_word = 32'h0;
				else if (r.op[0]) e.dest_low_word = r.first_source / r.second_source;
				// Overflow case pinned explicitly; native division there is not portable
				else if (r.first_source == 32'h80000000 && r.second_source == 32'hffffffff) e.dest_low_word = 32'h80000000;
				else e.dest_low_word = $signed(r.first_source) / $signed(r.second_source);
			end
		endcase
		return e;
	endfunction

	function automatic mdu_pkg::req_t mk(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
		mdu_pkg::req_t r;
		r = mdu_pkg::req_t'(145'({$urandom, $urandom, $urandom, $urandom, $urandom}));
		r.op = mdu_pkg::op_t'(op);
		r.first_source = a;
		r.second_source = b;
		return r;
	endfunction
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [72:0] got, input logic [72:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("mismatches %0d, compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic run(input mdu_pkg::req_t r);
		logic        div;
		logic [72:0] m;
		int          k;
		logic        took;
		div = r.op[3] & r.op[1];
		i_decoder_model.send(r, took);
		if (!took) begin
			n_mismatch++;
			tally_and_finish();
		end
		for (k = 0; k < 100; k++) begin
			@(negedge i_sys_clk);
			if (k == 0 && div) check(73'(o_req_ready), 73'h0);
			if (o_done === 1'b1) break;
			@(posedge i_sys_clk);
			// Random stalls only on divides, where the latency is not pinned
			i_clk_en <= div ? ($urandom % 5 != 0) : 1'b1;
		end
		if (k == 100) begin
			n_mismatch++;
			tally_and_finish();
		end
		if (!div) check(73'(k), 73'h0);
		m = div ? {32'hffffffff, 32'h0, 8'hff, 1'b0} : '1;
		check(o_rsp & m, model(r) & m);
		@(posedge i_sys_clk);
		i_clk_en <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(56022));
		repeat (4) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		run(mk(4'ha, 32'h80000000, 32'hffffffff));
		run(mk(4'ha, 32'hfffffff9, 32'h2));
		run(mk(4'ha, 32'h7, 32'hfffffffe));
		run(mk(4'hb, 32'hffffffff, 32'h0));
		run(mk(4'ha, 32'h5, 32'h0));
		run(mk(4'h3, 32'h80008000, 32'h80008000));
		run(mk(4'h9, 32'hffffffff, 32'h1));
		for (int i = 0; i < 240; i++) begin
			run(mk(4'(i % 12), $urandom, (i % 7 == 0) ? 32'($urandom % 9) : $urandom));
		end
		tally_and_finish();
	end
endmodule
